// *** verilog/tpg_top.sv ***
// Test pattern generator inserted between sensor stream and digital processing stage.
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "tpg_defs.svh"

// Function
// - Selector picks off or one of six patterns; off passes sensor data unchanged.
// - Pattern pixels come from internal logic, never from sensor or converter data.
// - Gain, black level and exposure cannot influence pattern pixel values.
// - Patterns one, two, three and six bypass the digital processing stage.
// - Patterns four and five go through the digital processing stage.
// - Pattern one is column plus row modulo 256, stationary.
// - Pattern two is column plus row plus frame counter modulo 256.
// - Frame counter increments by one on each acquisition start.
// - Moving patterns shift one pixel right to left per acquisition.
// - Pattern three is column plus row plus counter modulo 4096.
// - Pattern four equals pattern two before processing.
// - Pattern five equals pattern three before processing.
// - Pattern six, colour variants only, is a moving YUV diagonal gradient.
// - Low resolution variant makes patterns three and five 10-bit.
module tpg_top #(
    parameter bit COLOR = 1'b1,
    parameter bit LOW_RES = 1'b0
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Register bus.
    input wire tpg_pkg::tpg_apb_req_t apb_req,
    output tpg_pkg::tpg_apb_rsp_t apb_rsp,
    // Acquisition control.
    input wire logic acq_start,
    // Sensor pixel stream.
    input wire tpg_pkg::tpg_pix_t sens_pix,
    // Digital processing loop.
    output tpg_pkg::tpg_pix_t proc_pix,
    input wire tpg_pkg::tpg_pix_t proc_ret,
    // Transmitted stream and state.
    output tpg_pkg::tpg_pix_t out_pix,
    output logic [2:0] pattern_active,
    output logic proc_bypass
);

    tpg_pkg::tpg_top_st_t s_r;
    tpg_pkg::tpg_top_st_t s_nxt;
    logic [2:0] pattern_select;
    logic sof_now;
    logic [2:0] eff_sel;
    logic [15:0] cur_col;
    logic [15:0] cur_row;
    logic [15:0] cur_cnt;
    logic [15:0] gen_data;
    logic route_proc;

    tpg_apb_regs #(
        .COLOR(COLOR)
    ) u_regs (
        .mclk(mclk),
        .rst(rst),
        .apb_req(apb_req),
        .apb_rsp(apb_rsp),
        .active(s_r.active),
        .bypass(s_r.out_byp),
        .fcnt(s_r.fcnt),
        .sel(pattern_select)
    );

    tpg_pixel_gen #(
        .COLOR(COLOR),
        .LOW_RES(LOW_RES)
    ) u_gen (
        .sel(eff_sel),
        .col(cur_col),
        .row(cur_row),
        .cnt(cur_cnt),
        .data(gen_data)
    );

    // The first pixel of a frame already uses the newly selected pattern.
    assign sof_now = sens_pix.valid && sens_pix.sof;
    assign eff_sel = sof_now ? pattern_select : s_r.active;
    assign cur_col = sof_now ? `TPG_IDX_RST : s_r.col;
    assign cur_row = sof_now ? `TPG_IDX_RST : s_r.row;
    assign cur_cnt = sof_now ? s_r.fcnt : s_r.fused;
    assign route_proc = (eff_sel == `TPG_SEL_NONE) || (eff_sel == `TPG_SEL_FEAT8) ||
        (eff_sel == `TPG_SEL_FEAT12);

    always_comb begin
        s_nxt = s_r;
        if (sof_now) begin
            s_nxt.active = pattern_select;
            s_nxt.fused = s_r.fcnt;
            s_nxt.out_byp = !route_proc;
        end
        if (sens_pix.valid) begin
            if (sens_pix.eol) begin
                s_nxt.col = `TPG_IDX_RST;
                s_nxt.row = 16'(cur_row + 16'h0001);
            end else begin
                s_nxt.col = 16'(cur_col + 16'h0001);
                s_nxt.row = cur_row;
            end
        end
        if (acq_start) begin
            s_nxt.fcnt = 16'(s_r.fcnt + 16'h0001);
        end
        // With a pattern selected, only stream timing is taken from the sensor; analog settings act on
        // sensor data alone, which patterns discard.
        s_nxt.prc = sens_pix;
        s_nxt.prc.valid = sens_pix.valid && route_proc;
        if (eff_sel != `TPG_SEL_NONE) begin
            s_nxt.prc.data = gen_data;
        end
        s_nxt.stg = sens_pix;
        s_nxt.stg.valid = sens_pix.valid && !route_proc;
        s_nxt.stg.data = gen_data;
        s_nxt.stg_col = cur_col;
        s_nxt.stg_row = cur_row;
        s_nxt.stg_cnt = cur_cnt;
        s_nxt.stg_sel = eff_sel;
        s_nxt.out = s_r.out_byp ? s_r.stg : proc_ret;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign proc_pix = s_r.prc;
    assign out_pix = s_r.out;
    assign pattern_active = s_r.active;
    assign proc_bypass = s_r.out_byp;

    off_pass_a: assert property (
        @(posedge mclk) disable iff (rst)
        (sens_pix.valid && eff_sel == `TPG_SEL_NONE) |=>
            (s_r.prc.valid && s_r.prc.data == $past(sens_pix.data) && !s_r.stg.valid))
        else $error("Sensor data not passed when patterns are off.");

    no_sensor_a: assert property (
        @(posedge mclk) disable iff (rst)
        (sens_pix.valid && eff_sel != `TPG_SEL_NONE) |=>
            ((s_r.prc.valid ? s_r.prc.data : s_r.stg.data) == $past(gen_data)))
        else $error("Pattern pixel does not come from the generator.");

    bypass_route_a: assert property (
        @(posedge mclk) disable iff (rst)
        (sens_pix.valid && (eff_sel == `TPG_SEL_FIXED || eff_sel == `TPG_SEL_MOVE8 ||
            eff_sel == `TPG_SEL_MOVE12 || eff_sel == `TPG_SEL_COLOR)) |=>
            (s_r.stg.valid && !s_r.prc.valid))
        else $error("Bypass pattern was sent to processing.");

    proc_route_a: assert property (
        @(posedge mclk) disable iff (rst)
        (sens_pix.valid && (eff_sel == `TPG_SEL_FEAT8 || eff_sel == `TPG_SEL_FEAT12)) |=>
            (s_r.prc.valid && !s_r.stg.valid))
        else $error("Feature test pattern skipped processing.");

    proc_out_a: assert property (
        @(posedge mclk) disable iff (rst)
        (!s_r.out_byp) |=> (s_r.out == $past(proc_ret)))
        else $error("Processed stream not forwarded to output.");

    fixed_grad_a: assert property (
        @(posedge mclk) disable iff (rst)
        (s_r.stg.valid && s_r.stg_sel == `TPG_SEL_FIXED) |->
            (s_r.stg.data == {8'h00, 8'(s_r.stg_col + s_r.stg_row)}))
        else $error("Fixed gradient value wrong.");

    move_grad8_a: assert property (
        @(posedge mclk) disable iff (rst)
        (s_r.stg.valid && s_r.stg_sel == `TPG_SEL_MOVE8) |->
            (s_r.stg.data == {8'h00, 8'(s_r.stg_col + s_r.stg_row + s_r.stg_cnt)}))
        else $error("Moving 8-bit gradient value wrong.");

    feat_grad8_a: assert property (
        @(posedge mclk) disable iff (rst)
        (s_r.prc.valid && s_r.stg_sel == `TPG_SEL_FEAT8) |->
            (s_r.prc.data == {8'h00, 8'(s_r.stg_col + s_r.stg_row + s_r.stg_cnt)}))
        else $error("Feature 8-bit gradient value wrong.");

    grad12_a: assert property (
        @(posedge mclk) disable iff (rst)
        ((s_r.stg.valid && s_r.stg_sel == `TPG_SEL_MOVE12) ||
            (s_r.prc.valid && s_r.stg_sel == `TPG_SEL_FEAT12)) |->
            ((s_r.stg.valid ? s_r.stg.data : s_r.prc.data) == (LOW_RES ?
                {6'h00, 10'(s_r.stg_col + s_r.stg_row + s_r.stg_cnt)} :
                {4'h0, 12'(s_r.stg_col + s_r.stg_row + s_r.stg_cnt)})))
        else $error("Wide gradient value wrong.");

    fcnt_step_a: assert property (
        @(posedge mclk) disable iff (rst)
        acq_start |=> (s_r.fcnt == 16'($past(s_r.fcnt) + 16'h0001)))
        else $error("Frame counter did not advance on acquisition start.");

    fcnt_hold_a: assert property (
        @(posedge mclk) disable iff (rst)
        (!acq_start) |=> $stable(s_r.fcnt))
        else $error("Frame counter moved without acquisition start.");

    frame_shift_a: assert property (
        @(posedge mclk) disable iff (rst)
        (s_r.fused != $past(s_r.fused)) |-> $past(sof_now))
        else $error("Pattern offset changed inside a frame.");

    color_only_a: assert property (
        @(posedge mclk) disable iff (rst)
        (!COLOR) |-> (s_r.active != `TPG_SEL_COLOR))
        else $error("Colour pattern active on a mono variant.");

    origin_a: assert property (
        @(posedge mclk) disable iff (rst)
        sof_now |=> (s_r.stg_col == 16'h0000 && s_r.stg_row == 16'h0000))
        else $error("Frame does not start at the origin.");

    sel_frame_a: assert property (
        @(posedge mclk) disable iff (rst)
        (s_r.active != $past(s_r.active)) |-> $past(sof_now))
        else $error("Pattern changed inside a frame.");

    sel_write_a: assert property (
        @(posedge mclk) disable iff (rst)
        (apb_req.psel && apb_req.penable && apb_req.pwrite &&
            apb_req.paddr == `TPG_ADDR_CTRL && !apb_rsp.pslverr) |=>
            (pattern_select == $past(apb_req.pwdata[2:0])))
        else $error("Accepted selector write did not land.");

    sel_refuse_a: assert property (
        @(posedge mclk) disable iff (rst)
        (apb_req.psel && apb_req.penable && apb_rsp.pslverr) |=> $stable(pattern_select))
        else $error("Refused write changed the selector.");

    sel_legal_a: assert property (
        @(posedge mclk) disable iff (rst)
        (pattern_select <= `TPG_SEL_FEAT12) || (COLOR && pattern_select == `TPG_SEL_COLOR))
        else $error("Selector holds an undefined pattern code.");

    byp_choice_a: assert property (
        @(posedge mclk) disable iff (rst)
        sof_now |=> (s_r.out_byp == ($past(pattern_select) inside {`TPG_SEL_FIXED,
            `TPG_SEL_MOVE8, `TPG_SEL_MOVE12, `TPG_SEL_COLOR})))
        else $error("Bypass choice does not match the new pattern.");

    byp_out_a: assert property (
        @(posedge mclk) disable iff (rst)
        s_r.out_byp |=> (s_r.out == $past(s_r.stg)))
        else $error("Bypass stage not forwarded to output.");

    byp_quiet_a: assert property (
        @(posedge mclk) disable iff (rst)
        s_r.stg.valid |-> (s_r.out_byp && !s_r.prc.valid))
        else $error("Bypass pixel staged in a processing frame.");

    proc_hold_a: assert property (
        @(posedge mclk) disable iff (rst)
        s_r.out_byp |-> !s_r.prc.valid)
        else $error("Processing stage fed in a bypass frame.");

    byp_hold_a: assert property (
        @(posedge mclk) disable iff (rst)
        (!sof_now) |=> $stable(s_r.out_byp))
        else $error("Bypass route changed inside a frame.");

    pat_indep_a: assert property (
        @(posedge mclk) disable iff (rst)
        (sens_pix.valid && eff_sel != `TPG_SEL_NONE) |=>
            (s_r.stg.data == $past(gen_data) && s_r.stg.valid == !s_r.prc.valid))
        else $error("Pattern pixel lost or routed twice.");

    fused_latch_a: assert property (
        @(posedge mclk) disable iff (rst)
        sof_now |=> (s_r.fused == $past(s_r.fcnt) && s_r.stg_cnt == $past(s_r.fcnt)))
        else $error("Frame did not take the current frame count.");

    col_step_a: assert property (
        @(posedge mclk) disable iff (rst)
        (sens_pix.valid && !sens_pix.eol) |=>
            (s_r.col == 16'(s_r.stg_col + 16'h0001) && s_r.row == s_r.stg_row))
        else $error("Column index did not step.");

    line_wrap_a: assert property (
        @(posedge mclk) disable iff (rst)
        (sens_pix.valid && sens_pix.eol) |=>
            (s_r.col == 16'h0000 && s_r.row == 16'(s_r.stg_row + 16'h0001)))
        else $error("Line end did not move to the next row.");

    idx_hold_a: assert property (
        @(posedge mclk) disable iff (rst)
        (!sens_pix.valid) |=> ($stable(s_r.col) && $stable(s_r.row)))
        else $error("Pixel indices moved without a pixel.");

    color_grad_a: assert property (
        @(posedge mclk) disable iff (rst)
        (s_r.stg.valid && s_r.stg_sel == `TPG_SEL_COLOR) |->
            (s_r.stg.data[15:8] == 8'(s_r.stg_col + s_r.stg_row + s_r.stg_cnt) &&
            s_r.stg.data[7:0] == (s_r.stg_col[0] ?
                ~8'(s_r.stg_col - s_r.stg_row + s_r.stg_cnt) :
                8'(s_r.stg_col - s_r.stg_row + s_r.stg_cnt))))
        else $error("Colour gradient value wrong.");

endmodule : tpg_top

`default_nettype wire

// *** verilog/tpg_defs.svh ***
// Constants of the test pattern generator: selector codes, register map, fields and resets.
`ifndef TPG_DEFS_SVH
`define TPG_DEFS_SVH

`define TPG_SEL_NONE 3'h0
`define TPG_SEL_FIXED 3'h1
`define TPG_SEL_MOVE8 3'h2
`define TPG_SEL_MOVE12 3'h3
`define TPG_SEL_FEAT8 3'h4
`define TPG_SEL_FEAT12 3'h5
`define TPG_SEL_COLOR 3'h6

`define TPG_ADDR_CTRL 12'h000
`define TPG_ADDR_STATUS 12'h004
`define TPG_ADDR_FCNT 12'h008

`define TPG_CTRL_SEL_LSB 0
`define TPG_CTRL_SEL_MSB 2
`define TPG_STAT_ACT_LSB 0
`define TPG_STAT_ACT_MSB 2
`define TPG_STAT_BYP_BIT 4
`define TPG_FCNT_LSB 0
`define TPG_FCNT_MSB 15

`define TPG_SEL_RST 3'h0
`define TPG_FCNT_RST 16'h0000
`define TPG_IDX_RST 16'h0000

`endif

// *** verilog/tpg_pkg.sv ***
// Types shared by the test pattern generator modules.
`include "tpg_defs.svh"

package tpg_pkg;

    typedef struct packed {
        logic valid;
        logic sof;
        logic eol;
        logic [15:0] data;
    } tpg_pix_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } tpg_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tpg_apb_rsp_t;

    typedef struct packed {
        logic [2:0] sel;
        logic [31:0] rdata;
        logic err;
    } tpg_regs_st_t;

    typedef struct packed {
        logic [2:0] active;
        logic [15:0] col;
        logic [15:0] row;
        logic [15:0] fcnt;
        logic [15:0] fused;
        logic out_byp;
        tpg_pix_t prc;
        tpg_pix_t stg;
        logic [15:0] stg_col;
        logic [15:0] stg_row;
        logic [15:0] stg_cnt;
        logic [2:0] stg_sel;
        tpg_pix_t out;
    } tpg_top_st_t;

endpackage : tpg_pkg

// *** verilog/tpg_pixel_gen.sv ***
// Combinational pixel value generator for all synthetic patterns.
`timescale 1ns/10ps
`default_nettype none
`include "tpg_defs.svh"

module tpg_pixel_gen #(
    parameter bit COLOR = 1'b1,
    parameter bit LOW_RES = 1'b0
) (
    // Pattern and position.
    input wire logic [2:0] sel,
    input wire logic [15:0] col,
    input wire logic [15:0] row,
    input wire logic [15:0] cnt,
    // Generated value.
    output logic [15:0] data
);

    logic [15:0] sum_fix;
    logic [15:0] sum_mov;
    logic [15:0] chroma;

    always_comb begin
        sum_fix = 16'(col + row);
        sum_mov = 16'(col + row + cnt);
        chroma = 16'(col - row + cnt);
        data = 16'h0000;
        case (sel)
            `TPG_SEL_FIXED: data = {8'h00, sum_fix[7:0]};
            `TPG_SEL_MOVE8, `TPG_SEL_FEAT8: data = {8'h00, sum_mov[7:0]};
            `TPG_SEL_MOVE12, `TPG_SEL_FEAT12: begin
                if (LOW_RES) begin
                    data = {6'h00, sum_mov[9:0]};
                end else begin
                    data = {4'h0, sum_mov[11:0]};
                end
            end
            `TPG_SEL_COLOR: begin
                if (COLOR) begin
                    data = {sum_mov[7:0], col[0] ? ~chroma[7:0] : chroma[7:0]};
                end
            end
            default: data = 16'h0000;
        endcase
    end

endmodule : tpg_pixel_gen

`default_nettype wire

// *** verilog/tpg_apb_regs.sv ***
// APB register slave holding the pattern selector and showing generator state.
`timescale 1ns/10ps
`default_nettype none
`include "tpg_defs.svh"

module tpg_apb_regs #(
    parameter bit COLOR = 1'b1
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // APB.
    input wire tpg_pkg::tpg_apb_req_t apb_req,
    output tpg_pkg::tpg_apb_rsp_t apb_rsp,
    // Block state.
    input wire logic [2:0] active,
    input wire logic bypass,
    input wire logic [15:0] fcnt,
    output logic [2:0] sel
);

    tpg_pkg::tpg_regs_st_t s_r;
    tpg_pkg::tpg_regs_st_t s_nxt;
    logic sel_ok;

    assign sel_ok = (apb_req.pwdata[2:0] <= `TPG_SEL_FEAT12) ||
        (COLOR && apb_req.pwdata[2:0] == `TPG_SEL_COLOR);

    always_comb begin
        s_nxt = s_r;
        if (apb_req.psel && !apb_req.penable) begin
            s_nxt.err = 1'b0;
            case (apb_req.paddr)
                `TPG_ADDR_CTRL: begin
                    s_nxt.rdata = {29'h0, s_r.sel};
                    s_nxt.err = apb_req.pwrite && !sel_ok;
                end
                `TPG_ADDR_STATUS: begin
                    s_nxt.rdata = 32'h0;
                    s_nxt.rdata[`TPG_STAT_ACT_MSB:`TPG_STAT_ACT_LSB] = active;
                    s_nxt.rdata[`TPG_STAT_BYP_BIT] = bypass;
                end
                `TPG_ADDR_FCNT: s_nxt.rdata = {16'h0, fcnt};
                default: begin
                    s_nxt.rdata = 32'h0;
                    s_nxt.err = 1'b1;
                end
            endcase
        end
        if (apb_req.psel && apb_req.penable && apb_req.pwrite && !s_r.err &&
            apb_req.paddr == `TPG_ADDR_CTRL) begin
            s_nxt.sel = apb_req.pwdata[`TPG_CTRL_SEL_MSB:`TPG_CTRL_SEL_LSB];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_r <= '{sel: `TPG_SEL_RST, rdata: 32'h0, err: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sel = s_r.sel;
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && s_r.err;
    assign apb_rsp.prdata = s_r.rdata;

endmodule : tpg_apb_regs

`default_nettype wire

// *** test/tpg_proc_model.sv ***
// Model of the digital processing stage: one cycle of latency and an optional lookup.
`timescale 1ns/10ps
`default_nettype none
module tpg_proc_model (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Stream in and stream out.
    input wire tpg_pkg::tpg_pix_t pix_in,
    output tpg_pkg::tpg_pix_t pix_out,
    // Lookup enable.
    input wire logic lut_on
);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pix_out <= '0;
        end else if (pix_in.valid) begin
            pix_out <= '{1'b1, pix_in.sof, pix_in.eol,
                         lut_on ? (pix_in.data ^ 16'h0F0F) : pix_in.data};
        end else begin
            pix_out <= '{1'b0, 1'b0, 1'b0, ~pix_out.data};
        end
    end
endmodule : tpg_proc_model
`default_nettype wire

// *** test/test_pattern_generator_tb_top.sv ***
// Self-checking testbench of the test pattern generator.
`timescale 1ns/10ps
`default_nettype none
`include "tpg_defs.svh"
`define TB_CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module test_pattern_generator_tb_top;
    localparam int W = 4;
    localparam int H = 3;
    logic mclk, rst, acq, lut_on, byp, byp2;
    logic [2:0] act, act2;
    tpg_pkg::tpg_apb_req_t req;
    tpg_pkg::tpg_apb_rsp_t rsp, rsp2;
    tpg_pkg::tpg_pix_t sens, ppix, pret, opix, ppix2, pret2, opix2;
    int fail_count = 0;
    int n_tests = 0;
    int fexp = 0;
    logic [15:0] q[$], q2[$];

    tpg_top #(.COLOR(1'b1), .LOW_RES(1'b0)) i_dut (.mclk(mclk), .rst(rst), .apb_req(req),
        .apb_rsp(rsp), .acq_start(acq), .sens_pix(sens), .proc_pix(ppix), .proc_ret(pret),
        .out_pix(opix), .pattern_active(act), .proc_bypass(byp));
    tpg_proc_model i_proc (.mclk(mclk), .rst(rst), .pix_in(ppix), .pix_out(pret),
        .lut_on(lut_on));
    tpg_top #(.COLOR(1'b0), .LOW_RES(1'b1)) i_dut_mono (.mclk(mclk), .rst(rst),
        .apb_req(req), .apb_rsp(rsp2), .acq_start(acq), .sens_pix(sens), .proc_pix(ppix2),
        .proc_ret(pret2), .out_pix(opix2), .pattern_active(act2), .proc_bypass(byp2));
    tpg_proc_model i_proc_mono (.mclk(mclk), .rst(rst), .pix_in(ppix2), .pix_out(pret2),
        .lut_on(lut_on));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    always @(posedge mclk) if (opix.valid === 1'b1) q.push_back(opix.data);
    always @(posedge mclk) if (opix2.valid === 1'b1) q2.push_back(opix2.data);

    function automatic logic [15:0] sdat(input int c, input int r);
        return 16'(16'hC000 + r * 16 + c);
    endfunction : sdat

    function automatic logic [15:0] pat(input int s, input int c, input int r, input int f,
                                        input bit lr);
        case (s)
            1: return 16'((c + r) % 256);
            2, 4: return 16'((c + r + f) % 256);
            3, 5: return lr ? 16'((c + r + f) % 1024) : 16'((c + r + f) % 4096);
            default: return {8'(c + r + f), (c % 2 == 1) ? ~8'(c - r + f) : 8'(c - r + f)};
        endcase
    endfunction : pat

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [31:0] erd, input logic eerr);
        int n;
        logic eerr2;
        n = 0;
        eerr2 = eerr || (w && a == `TPG_ADDR_CTRL && d[2:0] == 3'h6);
        @(posedge mclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge mclk);
        req.penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        if (n >= 50) fail_count++;
        `TB_CHK("pslverr", eerr, rsp.pslverr)
        `TB_CHK("pslverr_mono", eerr2, rsp2.pslverr)
        if (!w) `TB_CHK("prdata", erd, rsp.prdata)
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : xfer

    task automatic pulse();
        acq <= 1'b1;
        @(posedge mclk);
        acq <= 1'b0;
        @(posedge mclk);
        fexp++;
    endtask : pulse

    task automatic run_frame(input int s);
        int c, r, sm;
        logic [15:0] e;
        q.delete();
        q2.delete();
        for (r = 0; r < H; r++) begin
            for (c = 0; c < W; c++) begin
                sens <= '{1'b1, (r == 0 && c == 0), (c == W - 1), sdat(c, r)};
                @(posedge mclk);
            end
        end
        sens <= '{1'b0, 1'b0, 1'b0, ~sens.data};
        repeat (10) @(posedge mclk);
        `TB_CHK("count", W * H, q.size())
        `TB_CHK("count_mono", W * H, q2.size())
        sm = (s == 6) ? 5 : s;
        for (r = 0; r < H; r++) begin
            for (c = 0; c < W; c++) begin
                e = (s == 0) ? sdat(c, r) : pat(s, c, r, fexp, 1'b0);
                if (lut_on && (s == 0 || s == 4 || s == 5)) e = e ^ 16'h0F0F;
                `TB_CHK("pixel", e, q[r * W + c])
                e = (sm == 0) ? sdat(c, r) : pat(sm, c, r, fexp, 1'b1);
                if (lut_on && (sm == 0 || sm == 4 || sm == 5)) e = e ^ 16'h0F0F;
                `TB_CHK("pixel_mono", e, q2[r * W + c])
            end
        end
    endtask : run_frame

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (5000) @(posedge mclk);
        fail_count++;
        tally_and_finish();
    end

    initial begin
        rst = 1'b1;
        req = '0;
        sens = '0;
        acq = 1'b0;
        lut_on = 1'b0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        xfer(1'b0, `TPG_ADDR_CTRL, 32'h0, 32'h0, 1'b0);
        xfer(1'b0, `TPG_ADDR_FCNT, 32'h0, 32'h0, 1'b0);
        run_frame(0);
        lut_on <= 1'b1;
        for (int s = 1; s <= 6; s++) begin
            xfer(1'b1, `TPG_ADDR_CTRL, 32'(s), 32'h0, 1'b0);
            pulse();
            run_frame(s);
            `TB_CHK("active", 3'(s), act)
            `TB_CHK("bypass", (s != 4 && s != 5), byp)
            `TB_CHK("active_mono", (s == 6) ? 3'h5 : 3'(s), act2)
            `TB_CHK("bypass_mono", (s != 4 && s != 5 && s != 6), byp2)
            xfer(1'b0, `TPG_ADDR_STATUS, 32'h0, 32'({(s != 4 && s != 5), 1'b0, 3'(s)}), 1'b0);
        end
        xfer(1'b1, `TPG_ADDR_CTRL, 32'h1, 32'h0, 1'b0);
        pulse();
        run_frame(1);
        xfer(1'b1, `TPG_ADDR_CTRL, 32'h2, 32'h0, 1'b0);
        pulse();
        fork
            run_frame(2);
            xfer(1'b1, `TPG_ADDR_CTRL, 32'h3, 32'h0, 1'b0);
        join
        pulse();
        run_frame(3);
        xfer(1'b0, `TPG_ADDR_FCNT, 32'h0, 32'(fexp), 1'b0);
        xfer(1'b1, `TPG_ADDR_CTRL, 32'h7, 32'h0, 1'b1);
        xfer(1'b0, `TPG_ADDR_CTRL, 32'h0, 32'h3, 1'b0);
        xfer(1'b1, `TPG_ADDR_STATUS, 32'h1, 32'h0, 1'b0);
        xfer(1'b0, 12'h00C, 32'h0, 32'h0, 1'b1);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        xfer(1'b0, `TPG_ADDR_FCNT, 32'h0, 32'h0, 1'b0);
        xfer(1'b0, `TPG_ADDR_CTRL, 32'h0, 32'h0, 1'b0);
        `TB_CHK("active_reset", 3'h0, act)
        tally_and_finish();
    end
endmodule : test_pattern_generator_tb_top
`default_nettype wire
